// *** cspc_pkg.sv ***
// Purpose: Constants and types of the stack and pointer core.
// Assumes: 40 MHz pclk, APB register access.
// Notes: Program memory size is the implemented word count.
package cspc_pkg;
    localparam int PC_W = 15;
    localparam int PM_W = 14;
    localparam int STK_DEPTH = 16;
    localparam int SP_W = 5;
    localparam int PTR_W = 16;
    localparam int BANK_W = 5;
    localparam int BANKS = 32;
    localparam int BANK_BYTES = 128;
    localparam int DM_AW = 12;
    localparam int GPR_BYTES = 80;
    localparam int GPR_OFS = 32;
    localparam int INSTR_COUNT = 49;
    localparam int PM_WORDS = 2048;
    localparam int PM_SEL_BIT = 15;
    localparam logic [14:0] RESET_VECTOR = 15'h0000;
    localparam logic [14:0] INT_VECTOR = 15'h0004;
    localparam logic [15:0] LIN_BASE = 16'h2000;
    localparam logic [15:0] LIN_END = LIN_BASE + 16'(GPR_BYTES * BANKS);
    // Register byte offsets.
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_FLAGS = 8'h04;
    localparam logic [7:0] A_MASK = 8'h08;
    localparam logic [7:0] A_PTR0 = 8'h0C;
    localparam logic [7:0] A_PTR1 = 8'h10;
    localparam logic [7:0] A_BANK = 8'h14;
    localparam logic [7:0] A_PC = 8'h18;
    localparam logic [7:0] A_DEPTH = 8'h1C;
    // Field positions and reset values.
    localparam int RSTEN_BIT = 0;
    localparam int OVF_BIT = 0;
    localparam int UNF_BIT = 1;
    localparam int FLAG_W = 2;
    localparam logic RSTEN_RST = 1'b1;
    localparam logic [1:0] MASK_RST = 2'h0;
    typedef enum logic [3:0] {
        OP_HOLD, OP_STEP, OP_GOTO, OP_REL, OP_CALL, OP_RET, OP_INT,
        OP_RETFIE, OP_DIRECT, OP_IND, OP_PTR_LD, OP_BANK
    } cspc_op_t;
endpackage

// *** cspc_core.sv ***
// Purpose: Program counter, return stack, pointers and shadows.
// Assumes: Program memory reads combinationally from pm_addr.
// Notes: Instruction decoding lives upstream on the op port.
// Functional notes
// - Return addresses sit in a 16-entry stack of 15-bit words.
// - Overflow or underflow sets its flag and, if enabled, resets.
// - Two 16-bit pointers reach every file register and program memory.
// - A pointer access to program memory takes one extra cycle.
// - Pointers address general RAM linearly across banks.
// - Interrupt entry saves both pointers and bank select in shadows, RETFIE restores them.
// - The program counter is 15 bits wide.
// - Program addresses above the implemented size wrap around.
// - The core has 49 instructions, some acting on the pointers.
// - Direct, indirect and relative addressing are supported.
// - Pointer bit 15 set makes a read return the word's low byte.
// - Pointer writes into program memory have no effect.
// - Data memory is 32 banks of 128 bytes chosen by bank select.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module cspc_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic op_valid,
    input wire cspc_pkg::cspc_op_t op_code,
    input wire logic op_wr,
    input wire logic op_sel,
    input wire logic [15:0] op_arg,
    input wire logic [7:0] op_wdata,
    output logic op_ready,
    output logic [14:0] pm_addr,
    input wire logic [13:0] pm_rdata,
    output logic [11:0] dm_addr,
    output logic dm_re,
    output logic dm_we,
    output logic [7:0] dm_wdata,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic soft_reset,
    output logic irq
);
    import cspc_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [14:0] pm_wrap(input logic [14:0] a);
        pm_wrap = a & 15'(PM_WORDS - 1);
    endfunction

    // Returns {hit, address} for a data-space pointer.
    function automatic logic [12:0] dm_map(input logic [15:0] p);
        logic [15:0] off;
        logic [4:0] bk;
        logic [6:0] ix;
        off = p - LIN_BASE;
        bk = 5'(off / 16'(GPR_BYTES));
        ix = 7'(off % 16'(GPR_BYTES));
        if (p < 16'(BANKS * BANK_BYTES)) begin
            dm_map = {1'b1, p[11:0]};
        end else if (p >= LIN_BASE && p < LIN_END) begin
            dm_map = {1'b1, bk, 7'(GPR_OFS) + ix};
        end else begin
            dm_map = 13'h0000;
        end
    endfunction

    typedef enum logic {ST_RUN, ST_FETCH} cspc_state_t;
    cspc_state_t state_r;
    logic [14:0] pc_r, pc_nxt, pm_addr_r, stk_top, stk_mem [STK_DEPTH];
    logic [15:0] ptr_r [2], sh_ptr_r [2], cur_ptr;
    logic [SP_W-1:0] sp_r;
    logic [4:0] bank_r, sh_bank_r;
    logic [1:0] flags_r, mask_r, w1c;
    logic [12:0] dmap;
    logic [11:0] dm_addr_r;
    logic [7:0] dm_wdata_r, rd_data_r;
    logic [31:0] prdata_r;
    logic rsten_r, dm_re_r, dm_we_r, rd_valid_r, fetch_rd_r, soft_reset_r;
    logic take, push, pop, ovf_ev, unf_ev, srst, pm_ind, apb_wr, addr_ok;

    // ------------------------------------------------------------
    // Operation decode
    // ------------------------------------------------------------
    assign op_ready = (state_r == ST_RUN);
    assign take = op_valid && op_ready;
    assign push = take && (op_code == OP_CALL || op_code == OP_INT);
    assign pop = take && (op_code == OP_RET || op_code == OP_RETFIE);
    assign ovf_ev = push && (sp_r == SP_W'(STK_DEPTH));
    assign unf_ev = pop && (sp_r == '0);
    assign srst = (ovf_ev || unf_ev) && rsten_r;
    assign cur_ptr = ptr_r[op_sel];
    assign pm_ind = cur_ptr[PM_SEL_BIT];
    assign dmap = dm_map(cur_ptr);
    assign stk_top = stk_mem[4'(sp_r - 5'd1)];

    // The 49 instructions map onto these operations upstream.
    always_comb begin
        case (op_code)
            OP_GOTO, OP_CALL: pc_nxt = pm_wrap(op_arg[14:0]);
            OP_REL: pc_nxt = pm_wrap(pc_r + 15'h0001 + op_arg[14:0]);
            OP_RET, OP_RETFIE: pc_nxt = unf_ev ? RESET_VECTOR : stk_top;
            OP_INT: pc_nxt = INT_VECTOR;
            OP_HOLD: pc_nxt = pc_r;
            default: pc_nxt = pm_wrap(pc_r + 15'h0001);
        endcase
    end

    // ------------------------------------------------------------
    // Program counter and stack
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_r <= RESET_VECTOR;
        end else if (srst) begin
            pc_r <= RESET_VECTOR;
        end else if (take) begin
            pc_r <= pc_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_r <= '0;
        end else if (srst) begin
            sp_r <= '0;
        end else if (push && !ovf_ev) begin
            sp_r <= sp_r + 5'd1;
        end else if (pop && !unf_ev) begin
            sp_r <= sp_r - 5'd1;
        end
    end

    // Interrupt entry saves the current address, a call the next one.
    always_ff @(posedge pclk) begin
        if (push && !ovf_ev) begin
            stk_mem[sp_r[3:0]] <= (op_code == OP_INT) ? pc_r
                : pm_wrap(pc_r + 15'h0001);
        end
    end

    // ------------------------------------------------------------
    // Pointers, bank select and shadows
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_r[0] <= 16'h0000;
            ptr_r[1] <= 16'h0000;
            bank_r <= '0;
        end else if (take && op_code == OP_PTR_LD) begin
            ptr_r[op_sel] <= op_arg;
        end else if (take && op_code == OP_BANK) begin
            bank_r <= op_arg[4:0];
        end else if (take && op_code == OP_RETFIE) begin
            ptr_r[0] <= sh_ptr_r[0];
            ptr_r[1] <= sh_ptr_r[1];
            bank_r <= sh_bank_r;
        end else if (apb_wr && paddr == A_PTR0) begin
            ptr_r[0] <= pwdata[15:0];
        end else if (apb_wr && paddr == A_PTR1) begin
            ptr_r[1] <= pwdata[15:0];
        end else if (apb_wr && paddr == A_BANK) begin
            bank_r <= pwdata[4:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_ptr_r[0] <= 16'h0000;
            sh_ptr_r[1] <= 16'h0000;
            sh_bank_r <= '0;
        end else if (take && op_code == OP_INT) begin
            sh_ptr_r[0] <= ptr_r[0];
            sh_ptr_r[1] <= ptr_r[1];
            sh_bank_r <= bank_r;
        end
    end

    // ------------------------------------------------------------
    // Memory access
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_RUN;
            fetch_rd_r <= 1'b0;
        end else begin
            case (state_r)
                ST_RUN: begin
                    if (take && op_code == OP_IND && pm_ind) begin
                        state_r <= ST_FETCH;
                        fetch_rd_r <= !op_wr;
                    end
                end
                ST_FETCH: state_r <= ST_RUN;
                default: state_r <= ST_RUN;
            endcase
        end
    end

    // Mirrors the counter except while a pointer fetch is running.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pm_addr_r <= RESET_VECTOR;
        end else if (srst) begin
            pm_addr_r <= RESET_VECTOR;
        end else if (take && op_code == OP_IND && pm_ind) begin
            pm_addr_r <= pm_wrap(cur_ptr[14:0]);
        end else if (take) begin
            pm_addr_r <= pc_nxt;
        end else begin
            pm_addr_r <= pc_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data_r <= 8'h00;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= (state_r == ST_FETCH) && fetch_rd_r;
            if (state_r == ST_FETCH && fetch_rd_r) begin
                rd_data_r <= pm_rdata[7:0];
            end
        end
    end

    // Program-space writes never raise a strobe.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dm_addr_r <= '0;
            dm_re_r <= 1'b0;
            dm_we_r <= 1'b0;
            dm_wdata_r <= 8'h00;
        end else begin
            dm_re_r <= 1'b0;
            dm_we_r <= 1'b0;
            if (take && op_code == OP_DIRECT) begin
                dm_addr_r <= {bank_r, op_arg[6:0]};
                dm_re_r <= !op_wr;
                dm_we_r <= op_wr;
                dm_wdata_r <= op_wdata;
            end else if (take && op_code == OP_IND && !pm_ind) begin
                dm_addr_r <= dmap[11:0];
                dm_re_r <= dmap[12] && !op_wr;
                dm_we_r <= dmap[12] && op_wr;
                dm_wdata_r <= op_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Flags, interrupt and register bus
    // ------------------------------------------------------------
    assign apb_wr = psel && penable && pwrite;
    assign w1c = (apb_wr && paddr == A_FLAGS) ? pwdata[1:0] : 2'h0;

    // A new event wins over a clear in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r <= '0;
            soft_reset_r <= 1'b0;
        end else begin
            soft_reset_r <= srst;
            flags_r[OVF_BIT] <= (flags_r[OVF_BIT] && !w1c[OVF_BIT])
                || ovf_ev;
            flags_r[UNF_BIT] <= (flags_r[UNF_BIT] && !w1c[UNF_BIT])
                || unf_ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= MASK_RST;
            rsten_r <= RSTEN_RST;
        end else if (apb_wr && paddr == A_MASK) begin
            mask_r <= pwdata[FLAG_W-1:0];
        end else if (apb_wr && paddr == A_CTRL) begin
            rsten_r <= pwdata[RSTEN_BIT];
        end
    end

    always_comb begin
        addr_ok = 1'b1;
        case (paddr)
            A_CTRL: prdata_r = {31'h0000_0000, rsten_r};
            A_FLAGS: prdata_r = {30'h0000_0000, flags_r};
            A_MASK: prdata_r = {30'h0000_0000, mask_r};
            A_PTR0: prdata_r = {16'h0000, ptr_r[0]};
            A_PTR1: prdata_r = {16'h0000, ptr_r[1]};
            A_BANK: prdata_r = {27'h000_0000, bank_r};
            A_PC: prdata_r = {17'h0_0000, pc_r};
            A_DEPTH: prdata_r = {27'h000_0000, sp_r};
            default: begin
                prdata_r = 32'h0000_0000;
                addr_ok = 1'b0;
            end
        endcase
    end

    // Read data is captured in the setup cycle, so no wait states.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= prdata_r;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign irq = |(flags_r & mask_r);
    assign pm_addr = pm_addr_r;
    assign dm_addr = dm_addr_r;
    assign dm_re = dm_re_r;
    assign dm_we = dm_we_r;
    assign dm_wdata = dm_wdata_r;
    assign rd_data = rd_data_r;
    assign rd_valid = rd_valid_r;
    assign soft_reset = soft_reset_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    pc_wrap_a: assert property (pm_addr < 15'(PM_WORDS))
        else $error("program address outside implemented space");
    ovf_flag_a: assert property (push && sp_r == SP_W'(STK_DEPTH)
        |=> flags_r[OVF_BIT] && (sp_r == SP_W'(STK_DEPTH) || sp_r == '0))
        else $error("overflow flag not set");
    unf_flag_a: assert property (pop && sp_r == '0
        |=> flags_r[UNF_BIT])
        else $error("underflow flag not set");
    soft_rst_a: assert property (srst |=> soft_reset && sp_r == '0
        && pc_r == RESET_VECTOR ##1 soft_reset == $past(srst))
        else $error("soft reset not taken");
    stack_push_a: assert property (push && sp_r < SP_W'(STK_DEPTH)
        |=> sp_r == $past(sp_r) + 5'h01)
        else $error("stack depth did not grow");
    pm_extra_a: assert property (take && op_code == OP_IND && pm_ind
        |=> !op_ready && !dm_we ##1 op_ready)
        else $error("program fetch not one extra cycle");
    pm_read_a: assert property (state_r == ST_FETCH && fetch_rd_r
        |=> rd_valid && rd_data == $past(pm_rdata[7:0]))
        else $error("program byte not returned");
    shadow_save_a: assert property (take && op_code == OP_INT
        |=> sh_bank_r == $past(bank_r) && sh_ptr_r[0] == $past(ptr_r[0])
        && sh_ptr_r[1] == $past(ptr_r[1]))
        else $error("shadow save mismatch");
    shadow_restore_a: assert property (take && op_code == OP_RETFIE
        |=> bank_r == $past(sh_bank_r) && ptr_r[0] == $past(sh_ptr_r[0])
        && ptr_r[1] == $past(sh_ptr_r[1]))
        else $error("shadow restore mismatch");
    lin_map_a: assert property (take && op_code == OP_IND && !pm_ind
        && cur_ptr >= LIN_BASE && cur_ptr < LIN_END
        |=> dm_addr[6:0] >= 7'h20 && dm_addr[6:0] < 7'h70)
        else $error("linear address outside general RAM");
    bank_sel_a: assert property (take && op_code == OP_DIRECT
        |=> dm_addr[11:7] == $past(bank_r))
        else $error("direct access used wrong bank");
endmodule // cspc_core

// *** cspc_mem_model.sv ***
// Purpose: Program and data memory arrays facing the core.
// Assumes: Program words read combinationally, data written on pclk.
// Notes: Program word i holds i*37+5 so every read can be predicted.
`timescale 1ns/1ps
module cspc_mem_model (
    input wire logic pclk,
    input wire logic [14:0] pm_addr,
    output logic [13:0] pm_rdata,
    input wire logic [11:0] dm_addr,
    input wire logic dm_we,
    input wire logic [7:0] dm_wdata
);
    import cspc_pkg::*;
    logic [13:0] pm [0:PM_WORDS-1];
    logic [7:0] dm [0:BANKS*BANK_BYTES-1];
    logic [11:0] last_wa;
    int n_we = 0;
    initial begin
        for (int i = 0; i < PM_WORDS; i++) pm[i] = 14'(i * 37 + 5);
    end
    // Only implemented words exist, so an unwrapped address reads unknown.
    assign pm_rdata = pm[pm_addr];
    always @(posedge pclk) begin
        if (dm_we === 1'b1) begin
            dm[dm_addr] <= dm_wdata;
            last_wa <= dm_addr;
            n_we <= n_we + 1;
        end
    end
endmodule // cspc_mem_model

// *** tb_top.sv ***
// Purpose: Self-checking bench of the stack and pointer core.
// Assumes: APB slave answers by pready; ops are held until taken.
// Notes: Memory arrays come from the partner model.
`timescale 1ns/1ps
module tb_top;
    import cspc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, op_wdata, rd_data, dm_wdata, got_rd;
    logic [31:0] pwdata, prdata, rdat;
    logic op_valid, op_wr, op_sel, op_ready;
    logic dm_re, dm_we, rd_valid, soft_reset, irq;
    cspc_op_t op_code;
    logic [15:0] op_arg;
    logic [14:0] pm_addr;
    logic [13:0] pm_rdata;
    logic [11:0] dm_addr;
    int n_errors = 0, check_count = 0, cyc = 0;
    int stalls = 0, n_soft = 0, n_re = 0, s0, w0;

    cspc_core dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .op_valid(op_valid), .op_code(op_code), .op_wr(op_wr),
        .op_sel(op_sel), .op_arg(op_arg), .op_wdata(op_wdata),
        .op_ready(op_ready), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
        .dm_addr(dm_addr), .dm_re(dm_re), .dm_we(dm_we),
        .dm_wdata(dm_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
        .soft_reset(soft_reset), .irq(irq));
    cspc_mem_model mem (.pclk(pclk), .pm_addr(pm_addr),
        .pm_rdata(pm_rdata), .dm_addr(dm_addr), .dm_we(dm_we),
        .dm_wdata(dm_wdata));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Counts refused cycles and captures pulses that last one cycle.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (op_ready !== 1'b1) stalls <= stalls + 1;
        if (rd_valid === 1'b1) got_rd <= rd_data;
        if (soft_reset === 1'b1) n_soft <= n_soft + 1;
        if (dm_re === 1'b1) n_re <= n_re + 1;
        if (cyc == 5000) begin
            $display("mismatch at %0t: timeout", $time);
            n_errors = n_errors + 1;
            test_done();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic test_done();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what,
                got, exp);
        end
    endtask
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdchk(logic [7:0] a, logic [31:0] exp, string what);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdat, exp, what);
    endtask
    task automatic op(cspc_op_t c, logic s, logic w, logic [15:0] a,
        logic [7:0] d);
        op_valid <= 1'b1;
        op_code <= c;
        op_sel <= s;
        op_wr <= w;
        op_arg <= a;
        op_wdata <= d;
        do @(posedge pclk); while (op_ready !== 1'b1);
        op_valid <= 1'b0;
        @(posedge pclk);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {op_valid, op_sel, op_wr, op_arg, op_wdata} = '0;
        op_code = OP_HOLD;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(A_CTRL, 32'h0000_0001, "ctrl reset");
        rdchk(A_FLAGS, 32'h0000_0000, "flags reset");
        rdchk(A_DEPTH, 32'h0000_0000, "depth reset");
        apb(1'b1, A_PC, 32'h0000_0123);
        rdchk(A_PC, 32'h0000_0000, "pc read only");
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk(err, 1'b1, "unmapped");
        op(OP_PTR_LD, 1'b0, 1'b0, 16'h2055, 8'h00);
        op(OP_PTR_LD, 1'b1, 1'b0, 16'h8010, 8'h00);
        s0 = stalls;
        op(OP_IND, 1'b1, 1'b0, 16'h0000, 8'h00);
        rdchk(A_PTR0, 32'h0000_2055, "ptr0");
        rdchk(A_PTR1, 32'h0000_8010, "ptr1");
        chk(stalls - s0, 1, "extra fetch cycle");
        chk(got_rd, 8'h55, "program low byte");
        w0 = mem.n_we;
        op(OP_IND, 1'b1, 1'b1, 16'h0000, 8'h5A);
        op(OP_IND, 1'b0, 1'b1, 16'h0000, 8'hA7);
        @(posedge pclk);
        chk(mem.n_we - w0, 1, "program write ignored");
        chk(mem.last_wa, 12'h0A5, "linear address");
        chk(mem.dm[12'h0A5], 8'hA7, "linear data");
        op(OP_BANK, 1'b0, 1'b0, 16'h0003, 8'h00);
        op(OP_DIRECT, 1'b0, 1'b1, 16'h0015, 8'h3C);
        @(posedge pclk);
        chk(mem.last_wa, 12'h195, "banked address");
        s0 = n_re;
        op(OP_DIRECT, 1'b0, 1'b0, 16'h0016, 8'h00);
        @(posedge pclk);
        chk(n_re - s0, 1, "direct read strobe");
        chk(dm_addr, 12'h196, "direct read address");
        op(OP_PTR_LD, 1'b0, 1'b0, 16'h0123, 8'h00);
        op(OP_IND, 1'b0, 1'b1, 16'h0000, 8'h66);
        @(posedge pclk);
        chk(mem.last_wa, 12'h123, "indirect address");
        op(OP_GOTO, 1'b0, 1'b0, 16'h7FF5, 8'h00);
        rdchk(A_PC, 32'h0000_07F5, "goto wraps");
        op(OP_REL, 1'b0, 1'b0, 16'h000A, 8'h00);
        chk(pm_addr, 15'h0000, "relative wraps");
        op(OP_STEP, 1'b0, 1'b0, 16'h0000, 8'h00);
        chk(pm_addr, 15'h0001, "step");
        op(OP_HOLD, 1'b0, 1'b0, 16'h0000, 8'h00);
        chk(pm_addr, 15'h0001, "hold");
        op(OP_GOTO, 1'b0, 1'b0, 16'h0040, 8'h00);
        op(OP_PTR_LD, 1'b0, 1'b0, 16'h0111, 8'h00);
        op(OP_INT, 1'b0, 1'b0, 16'h0000, 8'h00);
        chk(pm_addr, INT_VECTOR, "interrupt vector");
        op(OP_PTR_LD, 1'b0, 1'b0, 16'h0333, 8'h00);
        op(OP_BANK, 1'b0, 1'b0, 16'h0007, 8'h00);
        op(OP_RETFIE, 1'b0, 1'b0, 16'h0000, 8'h00);
        chk(pm_addr, 15'h0041, "interrupt return");
        rdchk(A_PTR0, 32'h0000_0111, "pointer restored");
        rdchk(A_BANK, 32'h0000_0003, "bank restored");
        apb(1'b1, A_CTRL, 32'h0000_0000);
        op(OP_GOTO, 1'b0, 1'b0, 16'h0100, 8'h00);
        for (int i = 0; i < 17; i++) begin
            op(OP_CALL, 1'b0, 1'b0, 16'(16'h0200 + i), 8'h00);
        end
        rdchk(A_DEPTH, STK_DEPTH, "depth full");
        rdchk(A_FLAGS, 32'h0000_0001, "overflow flag");
        chk(irq, 1'b0, "irq masked");
        apb(1'b1, A_MASK, 32'h0000_0003);
        chk(irq, 1'b1, "irq raised");
        apb(1'b1, A_FLAGS, 32'h0000_0001);
        chk(irq, 1'b0, "irq cleared");
        op(OP_RET, 1'b0, 1'b0, 16'h0000, 8'h00);
        chk(pm_addr, 15'h020F, "return address");
        for (int i = 0; i < 15; i++) begin
            op(OP_RET, 1'b0, 1'b0, 16'h0000, 8'h00);
        end
        chk(pm_addr, 15'h0101, "stack bottom");
        s0 = n_soft;
        op(OP_RET, 1'b0, 1'b0, 16'h0000, 8'h00);
        rdchk(A_FLAGS, 32'h0000_0002, "underflow flag");
        chk(irq, 1'b1, "irq underflow");
        chk(n_soft - s0, 0, "reset disabled");
        apb(1'b1, A_CTRL, 32'h0000_0001);
        op(OP_RET, 1'b0, 1'b0, 16'h0000, 8'h00);
        repeat (2) @(posedge pclk);
        chk(n_soft - s0, 1, "soft reset pulse");
        chk(pm_addr, RESET_VECTOR, "restart address");
        test_done();
    end
endmodule // tb_top
